/* verilog/ops_consts.svh */
`ifndef OPS_CONSTS_SVH
`define OPS_CONSTS_SVH

// Timing
`define OPS_CLK_HZ            100000000
`define OPS_NAME_HOLD_MS      1000
`define OPS_NAME_HOLD_CYCLES  (`OPS_NAME_HOLD_MS * (`OPS_CLK_HZ / 1000))

// Power and threshold range, whole dBm, two's complement
`define OPS_DBM_MAX           8'sh05
`define OPS_DBM_MIN           8'shD8
`define OPS_THR_RESET         8'shEC

// Single characters
`define OPS_CHR_ZERO          8'h30
`define OPS_CHR_PLUS          8'h2B
`define OPS_CHR_MINUS         8'h2D
`define OPS_CHR_SPACE         8'h20

// Four-character display texts, leftmost character in the top byte
`define OPS_TXT_POWER_FIRST   32'h50575241
`define OPS_TXT_POWER_SECOND  32'h50575242
`define OPS_TXT_THR_FIRST     32'h4D494E41
`define OPS_TXT_THR_SECOND    32'h4D494E42
`define OPS_TXT_STATUS        32'h53544154
`define OPS_TXT_ORIENT        32'h44495350
`define OPS_TXT_UPRIGHT       32'h56455254
`define OPS_TXT_SIDEWAYS      32'h484F5220
`define OPS_TXT_OVER          32'h3E2B3520
`define OPS_TXT_UNDER         32'h3C2D3430
`define OPS_TXT_IN1_HIGH      32'h49312D48
`define OPS_TXT_IN1_LOW       32'h49312D4C
`define OPS_TXT_IN2_HIGH      32'h49322D48
`define OPS_TXT_IN2_LOW       32'h49322D4C
`define OPS_TXT_RELAY_ON      32'h4F2D4F4E
`define OPS_TXT_RELAY_OPEN    32'h4F2D4F46
`define OPS_TXT_ROUTE_FIRST   32'h43482D41
`define OPS_TXT_ROUTE_SECOND  32'h43482D42

`endif

/* verilog/ops_pkg.sv */
package ops_pkg;

    typedef logic signed [7:0] ops_dbm_t;

    typedef enum logic [2:0] {
        MODE_SHOW_POWER_FIRST,
        MODE_SHOW_POWER_SECOND,
        MODE_SET_THRESHOLD_FIRST,
        MODE_SET_THRESHOLD_SECOND,
        MODE_STATUS,
        MODE_ORIENTATION_VIEW
    } ops_mode_t;

    typedef enum logic [1:0] {
        STEP_CONTACT_ONE,
        STEP_CONTACT_TWO,
        STEP_RELAY,
        STEP_ROUTE
    } ops_status_t;

endpackage

/* verilog/ops_orientation_view_if.sv */
`timescale 1ns/1ps
interface ops_orientation_view_if;
    import ops_pkg::*;

    ops_mode_t   mode;
    logic        show_data;
    ops_status_t status_step;
    logic        upright_text;
    ops_dbm_t    power_a;
    ops_dbm_t    power_b;
    ops_dbm_t    thr_a;
    ops_dbm_t    thr_b;
    logic        contact_one_pin;
    logic        contact_two_pin;
    logic        relay_closed;
    logic        route_second;

    modport ctrl (
        output mode, show_data, status_step, upright_text, power_a, power_b,
               thr_a, thr_b, contact_one_pin, contact_two_pin, relay_closed,
               route_second
    );
    modport orientation_view (
        input  mode, show_data, status_step, upright_text, power_a, power_b,
               thr_a, thr_b, contact_one_pin, contact_two_pin, relay_closed,
               route_second
    );
endinterface

/* verilog/ops_orientation_view.sv */
`timescale 1ns/1ps
`include "ops_consts.svh"
module ops_orientation_view
    import ops_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  sys_rst,
    // Display state from the controller
    ops_orientation_view_if.orientation_view   dsp,
    // Four characters, leftmost in the top byte
    output logic [31:0] orientation_view_text
);

    // Whole dBm in sign, tens, ones form, with a leading blank
    function automatic logic [31:0] fmt_dbm(input ops_dbm_t v);
        logic [7:0] mag;
        logic [7:0] tens;
        logic [7:0] ones;
        mag  = v[7] ? 8'(-v) : 8'(v);
        tens = mag / 8'h0A;
        ones = mag % 8'h0A;
        fmt_dbm = {`OPS_CHR_SPACE, v[7] ? `OPS_CHR_MINUS : `OPS_CHR_PLUS,
                   8'(`OPS_CHR_ZERO + tens), 8'(`OPS_CHR_ZERO + ones)};
    endfunction

    function automatic logic [31:0] fmt_power(input ops_dbm_t v);
        if (v > `OPS_DBM_MAX)
            fmt_power = `OPS_TXT_OVER;
        else if (v < `OPS_DBM_MIN)
            fmt_power = `OPS_TXT_UNDER;
        else
            fmt_power = fmt_dbm(v);
    endfunction

    logic [31:0] name_text;
    logic [31:0] data_text;
    logic [31:0] status_text;
    logic [31:0] next_text;

    assign name_text =
        (dsp.mode == MODE_SHOW_POWER_FIRST)     ? `OPS_TXT_POWER_FIRST  :
        (dsp.mode == MODE_SHOW_POWER_SECOND)    ? `OPS_TXT_POWER_SECOND :
        (dsp.mode == MODE_SET_THRESHOLD_FIRST)  ? `OPS_TXT_THR_FIRST    :
        (dsp.mode == MODE_SET_THRESHOLD_SECOND) ? `OPS_TXT_THR_SECOND   :
        (dsp.mode == MODE_STATUS)               ? `OPS_TXT_STATUS       :
                                                  `OPS_TXT_ORIENT;

    // Contacts show the pin level, so an asserted contact reads low
    assign status_text =
        (dsp.status_step == STEP_CONTACT_ONE) ?
            (dsp.contact_one_pin ? `OPS_TXT_IN1_HIGH : `OPS_TXT_IN1_LOW) :
        (dsp.status_step == STEP_CONTACT_TWO) ?
            (dsp.contact_two_pin ? `OPS_TXT_IN2_HIGH : `OPS_TXT_IN2_LOW) :
        (dsp.status_step == STEP_RELAY) ?
            (dsp.relay_closed ? `OPS_TXT_RELAY_ON : `OPS_TXT_RELAY_OPEN) :
            (dsp.route_second ? `OPS_TXT_ROUTE_SECOND : `OPS_TXT_ROUTE_FIRST);

    assign data_text =
        (dsp.mode == MODE_SHOW_POWER_FIRST)     ? fmt_power(dsp.power_a) :
        (dsp.mode == MODE_SHOW_POWER_SECOND)    ? fmt_power(dsp.power_b) :
        (dsp.mode == MODE_SET_THRESHOLD_FIRST)  ? fmt_dbm(dsp.thr_a)     :
        (dsp.mode == MODE_SET_THRESHOLD_SECOND) ? fmt_dbm(dsp.thr_b)     :
        (dsp.mode == MODE_STATUS)               ? status_text            :
        (dsp.upright_text ? `OPS_TXT_UPRIGHT : `OPS_TXT_SIDEWAYS);

    assign next_text = dsp.show_data ? data_text : name_text;

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            orientation_view_text <= `OPS_TXT_POWER_FIRST;
        else
            orientation_view_text <= next_text;
    end

endmodule

/* verilog/ops_ctrl.sv */
`timescale 1ns/1ps
`include "ops_consts.svh"
module ops_ctrl
    import ops_pkg::*;
#(
    parameter int NAME_HOLD_CYCLES = `OPS_NAME_HOLD_CYCLES
)(
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  sys_rst,
    // Measured optical power, whole dBm
    input  ops_dbm_t   power_a_dbm,
    input  ops_dbm_t   power_b_dbm,
    // Contact closure inputs, pin level
    input  wire logic  contact_input_one_n,
    input  wire logic  contact_input_two_n,
    // Configuration switches, high is on
    input  wire logic  cfg_switch_back,
    input  wire logic  cfg_manual,
    input  wire logic  cfg_buzzer_en,
    input  wire logic  cfg_dual_contact,
    // Board power monitors
    input  wire logic  frame_power_fault,
    input  wire logic  board_power_good,
    // Front panel controls, one-cycle pulses
    input  wire logic  button_press,
    input  wire logic  toggle_up,
    input  wire logic  toggle_down,
    // Indicators
    output logic       local_fault_led,
    output logic       module_ok_led,
    output logic       chan_a_low_power_led,
    output logic       chan_b_low_power_led,
    output logic       chan_a_selected_led,
    output logic       chan_b_selected_led,
    output logic       fault_buzzer,
    output logic       frame_fault,
    // Optical switch actuator and contact output relay
    output logic       route_second,
    output logic       relay_closed,
    // Display
    output logic [31:0] orientation_view_text,
    output logic       orientation_view_upright
);

    localparam int HOLD_W = $clog2(NAME_HOLD_CYCLES + 1);

    ops_orientation_view_if dif ();

    // Display menu state
    ops_mode_t    mode;
    logic         show_data;
    logic [HOLD_W-1:0] hold_cnt;
    ops_status_t  status_step;
    ops_dbm_t     thr_a;
    ops_dbm_t     thr_b;

    // Decoded inputs
    wire logic contact_one_act = ~contact_input_one_n;
    wire logic contact_two_act = ~contact_input_two_n;
    wire logic toggle_press    = toggle_up | toggle_down;
    // Exactly one contact asserted; none or both leave a dual-mode route alone
    wire logic one_only        = contact_one_act & ~contact_two_act;
    wire logic two_only        = contact_two_act & ~contact_one_act;

    // Per-channel validity; equal to threshold is treated as valid
    wire ops_dbm_t   chan_power [2];
    wire ops_dbm_t   chan_thr   [2];
    wire logic [1:0] chan_valid;
    assign chan_power[0] = power_a_dbm;
    assign chan_power[1] = power_b_dbm;
    assign chan_thr[0]   = thr_a;
    assign chan_thr[1]   = thr_b;
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            assign chan_valid[ch] = chan_power[ch] >= chan_thr[ch];
        end
    endgenerate
    wire logic valid_a = chan_valid[0];
    wire logic valid_b = chan_valid[1];
    wire logic valid_sel = route_second ? valid_b : valid_a;

    // Main input is A whatever the route, so a fault can stand while on B
    wire logic next_fault = ~valid_a | frame_power_fault;
    wire logic next_ok    = valid_sel & board_power_good;

    // Route selection
    logic next_route;
    always_comb begin
        next_route = route_second;
        if (cfg_manual) begin
            if (!cfg_dual_contact)
                next_route = ~contact_one_act;
            else if (one_only)
                next_route = 1'b0;
            else if (two_only)
                next_route = 1'b1;
            else
                next_route = route_second;
        end else begin
            // Contact one wins when both are asserted
            if (contact_one_act)
                next_route = 1'b0;
            else if (contact_two_act)
                next_route = 1'b1;
            else if (!valid_a)
                next_route = 1'b1;
            else if (cfg_switch_back)
                next_route = 1'b0;
            // A recovered first input does not pull the route back here
            else
                next_route = route_second;
        end
    end

    // Menu mode stepping
    ops_mode_t next_mode;
    always_comb begin
        // Spare enum codes fall back to the first mode
        unique case (mode)
            MODE_SHOW_POWER_FIRST:     next_mode = MODE_SHOW_POWER_SECOND;
            MODE_SHOW_POWER_SECOND:    next_mode = MODE_SET_THRESHOLD_FIRST;
            MODE_SET_THRESHOLD_FIRST:  next_mode = MODE_SET_THRESHOLD_SECOND;
            MODE_SET_THRESHOLD_SECOND: next_mode = MODE_STATUS;
            MODE_STATUS:               next_mode = MODE_ORIENTATION_VIEW;
            MODE_ORIENTATION_VIEW:     next_mode = MODE_SHOW_POWER_FIRST;
            default:                   next_mode = MODE_SHOW_POWER_FIRST;
        endcase
    end

    // Threshold stepping, clamped to the settable range
    wire logic thr_inc = toggle_up & ~toggle_down;
    wire logic thr_dec = toggle_down & ~toggle_up;
    wire logic edit_a  = mode == MODE_SET_THRESHOLD_FIRST;
    wire logic edit_b  = mode == MODE_SET_THRESHOLD_SECOND;

    // A toggle in the press cycle is dropped in status and orientation modes rather than applied to the new mode; a threshold mode still steps its threshold
    wire logic status_advance = mode == MODE_STATUS && toggle_press;
    wire logic orient_flip    = !button_press && mode == MODE_ORIENTATION_VIEW && toggle_press;

    function automatic ops_dbm_t step_thr(input ops_dbm_t t, input logic up,
                                          input logic dn);
        if (up && t < `OPS_DBM_MAX)
            step_thr = 8'(t + 8'sh01);
        else if (dn && t > `OPS_DBM_MIN)
            step_thr = 8'(t - 8'sh01);
        else
            step_thr = t;
    endfunction

    wire ops_dbm_t next_thr_a = edit_a ? step_thr(thr_a, thr_inc, thr_dec)
                                       : thr_a;
    wire ops_dbm_t next_thr_b = edit_b ? step_thr(thr_b, thr_inc, thr_dec)
                                       : thr_b;

    wire logic hold_done = hold_cnt == HOLD_W'(NAME_HOLD_CYCLES - 1);
    wire logic [HOLD_W-1:0] next_hold_cnt = hold_done ? '0 : HOLD_W'(hold_cnt + 1'b1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            mode <= MODE_SHOW_POWER_FIRST;
        else if (button_press)
            mode <= next_mode;
    end

    // Name phase timer; any press restarts it, so each name gets a full second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            show_data <= 1'b0;
            hold_cnt  <= '0;
        end else if (button_press) begin
            show_data <= 1'b0;
            hold_cnt  <= '0;
        end else if (!show_data) begin
            show_data <= hold_done;
            hold_cnt  <= next_hold_cnt;
        end
    end

    // Each threshold keeps its value while other modes are shown
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            thr_a <= `OPS_THR_RESET;
        else
            thr_a <= next_thr_a;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            thr_b <= `OPS_THR_RESET;
        else
            thr_b <= next_thr_b;
    end

    // Status sub-display restarts on every entry to status mode
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            status_step <= STEP_CONTACT_ONE;
        else if (button_press)
            status_step <= STEP_CONTACT_ONE;
        else if (status_advance)
            status_step <= ops_status_t'(status_step + 2'h1);
    end

    // Upright text out of reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            orientation_view_upright <= 1'b1;
        else if (orient_flip)
            orientation_view_upright <= ~orientation_view_upright;
    end

    // Actuator and selected indicators share one next value, so they agree after reset; reset clears both indicators
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            route_second        <= 1'b0;
            chan_a_selected_led <= 1'b0;
            chan_b_selected_led <= 1'b0;
        end else begin
            route_second        <= next_route;
            chan_a_selected_led <= ~next_route;
            chan_b_selected_led <= next_route;
        end
    end

    // Local fault fan-out; the contact relay simply follows it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            local_fault_led <= 1'b0;
            frame_fault     <= 1'b0;
            relay_closed    <= 1'b0;
            fault_buzzer    <= 1'b0;
        end else begin
            local_fault_led <= next_fault;
            frame_fault     <= next_fault;
            relay_closed    <= next_fault;
            fault_buzzer    <= next_fault & cfg_buzzer_en;
        end
    end

    // Health looks at the route as it stood before this edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            module_ok_led <= 1'b0;
        else
            module_ok_led <= next_ok;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chan_a_low_power_led <= 1'b0;
            chan_b_low_power_led <= 1'b0;
        end else begin
            chan_a_low_power_led <= ~valid_a;
            chan_b_low_power_led <= ~valid_b;
        end
    end

    // Feed the display formatter
    assign dif.mode            = mode;
    assign dif.show_data       = show_data;
    assign dif.status_step     = status_step;
    assign dif.upright_text    = orientation_view_upright;
    assign dif.power_a         = power_a_dbm;
    assign dif.power_b         = power_b_dbm;
    assign dif.thr_a           = thr_a;
    assign dif.thr_b           = thr_b;
    assign dif.contact_one_pin = contact_input_one_n;
    assign dif.contact_two_pin = contact_input_two_n;
    assign dif.relay_closed    = relay_closed;
    assign dif.route_second    = route_second;

    ops_orientation_view u_orientation_view (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .dsp       (dif.orientation_view),
        .orientation_view_text (orientation_view_text)
    );

endmodule

/* dv/ops_front_model.sv */
`timescale 1ns/1ps
module ops_front_model
    import ops_pkg::*;
(
    // Requests from the bench
    input  wire logic  one_asserted,
    input  wire logic  two_asserted,
    input  ops_dbm_t   level_a,
    input  ops_dbm_t   level_b,
    // Pins toward the controller
    output logic       contact_input_one_n,
    output logic       contact_input_two_n,
    output ops_dbm_t   power_a_dbm,
    output ops_dbm_t   power_b_dbm
);
    // Open contact rests on the pull-up, never on a stale level
    assign contact_input_one_n = one_asserted ? 1'b0 : 1'b1;
    assign contact_input_two_n = two_asserted ? 1'b0 : 1'b1;
    assign power_a_dbm = level_a;
    assign power_b_dbm = level_b;
endmodule

/* dv/ops_ctrl_asserts.sv */
`timescale 1ns/1ps
`include "ops_consts.svh"
module ops_ctrl_asserts
    import ops_pkg::*;
#(
    parameter int NAME_HOLD_CYCLES = 8
)(
    // Controller inputs
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        contact_input_one_n,
    input wire logic        contact_input_two_n,
    input wire logic        cfg_manual,
    input wire logic        cfg_dual_contact,
    input wire logic        cfg_buzzer_en,
    input wire logic        frame_power_fault,
    input wire logic        board_power_good,
    input wire logic        button_press,
    // Controller outputs
    input wire logic        local_fault_led,
    input wire logic        module_ok_led,
    input wire logic        chan_a_selected_led,
    input wire logic        chan_b_selected_led,
    input wire logic        fault_buzzer,
    input wire logic        frame_fault,
    input wire logic        relay_closed,
    input wire logic        route_second,
    input wire logic [31:0] orientation_view_text
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_fault_on;
        frame_power_fault |=> local_fault_led;
    endproperty
    a_fault_on: assert property (p_fault_on) else $error("fault led off");
    property p_ok_off;
        !board_power_good |=> !module_ok_led;
    endproperty
    a_ok_off: assert property (p_ok_off) else $error("ok led on");
    property p_one_sel;
        !sys_rst |=> (chan_a_selected_led ^ chan_b_selected_led)
            && chan_b_selected_led == route_second;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("selected leds");
    property p_name_first;
        button_press |-> ##2 orientation_view_text inside {`OPS_TXT_POWER_FIRST, `OPS_TXT_POWER_SECOND,
            `OPS_TXT_THR_FIRST, `OPS_TXT_THR_SECOND, `OPS_TXT_STATUS, `OPS_TXT_ORIENT};
    endproperty
    a_name_first: assert property (p_name_first) else $error("no mode name");
    property p_single;
        cfg_manual && !cfg_dual_contact |=> route_second == $past(contact_input_one_n);
    endproperty
    a_single: assert property (p_single) else $error("single manual route");
    property p_force_a;
        !cfg_manual && !contact_input_one_n |=> !route_second;
    endproperty
    a_force_a: assert property (p_force_a) else $error("contact one route");
    property p_buzz;
        !sys_rst |=> fault_buzzer == (local_fault_led && $past(cfg_buzzer_en));
    endproperty
    a_buzz: assert property (p_buzz) else $error("buzzer");
    property p_frame;
        frame_fault == local_fault_led && relay_closed == local_fault_led;
    endproperty
    a_frame: assert property (p_frame) else $error("frame fault");
    property p_dual_hold;
        cfg_manual && cfg_dual_contact && contact_input_one_n == contact_input_two_n
            |=> $stable(route_second);
    endproperty
    a_dual_hold: assert property (p_dual_hold) else $error("dual hold");
endmodule

/* dv/test_optical_protection_switch_ctrl.sv */
`timescale 1ns/1ps
`include "ops_consts.svh"
module test_optical_protection_switch_ctrl
    import ops_pkg::*;
();
    localparam int HOLD = 8;
    logic        clk_sys, sys_rst, button_press, toggle_up, toggle_down;
    logic        one_asserted, two_asserted, frame_power_fault, board_power_good;
    logic        cfg_switch_back, cfg_manual, cfg_buzzer_en, cfg_dual_contact;
    logic        contact_input_one_n, contact_input_two_n, exp_rt;
    logic        local_fault_led, module_ok_led, fault_buzzer, frame_fault, relay_closed;
    logic        chan_a_low_power_led, chan_b_low_power_led, orientation_view_upright;
    logic        chan_a_selected_led, chan_b_selected_led, route_second;
    logic [31:0] orientation_view_text, seed;
    ops_dbm_t    level_a, level_b, power_a_dbm, power_b_dbm, thr_a, thr_b;
    int          failures, cmp_count;

    ops_front_model u_front (.one_asserted, .two_asserted, .level_a, .level_b,
        .contact_input_one_n, .contact_input_two_n, .power_a_dbm, .power_b_dbm);

    ops_ctrl #(.NAME_HOLD_CYCLES(HOLD)) DUT (.clk_sys, .sys_rst, .power_a_dbm, .power_b_dbm,
        .contact_input_one_n, .contact_input_two_n, .cfg_switch_back, .cfg_manual,
        .cfg_buzzer_en, .cfg_dual_contact, .frame_power_fault, .board_power_good,
        .button_press, .toggle_up, .toggle_down, .local_fault_led, .module_ok_led,
        .chan_a_low_power_led, .chan_b_low_power_led, .chan_a_selected_led,
        .chan_b_selected_led, .fault_buzzer, .frame_fault, .route_second, .relay_closed,
        .orientation_view_text, .orientation_view_upright);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] fmt(input ops_dbm_t v);
        logic [7:0] m;
        if (v > `OPS_DBM_MAX) return `OPS_TXT_OVER;
        if (v < `OPS_DBM_MIN) return `OPS_TXT_UNDER;
        m = (v < 0) ? 8'(-v) : 8'(v);
        return {`OPS_CHR_SPACE, (v < 0) ? `OPS_CHR_MINUS : `OPS_CHR_PLUS,
                `OPS_CHR_ZERO + m / 8'h0A, `OPS_CHR_ZERO + m % 8'h0A};
    endfunction

    function automatic logic exp_route(input logic prev);
        if (cfg_manual && !cfg_dual_contact) return !one_asserted;
        if (cfg_manual) return (one_asserted == two_asserted) ? prev : two_asserted;
        if (one_asserted || two_asserted) return !one_asserted;
        if (level_a < thr_a) return 1'b1;
        return cfg_switch_back ? 1'b0 : prev;
    endfunction

    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_text(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Inputs are held two edges so the one-cycle latency has settled
    task automatic settle;
        logic va, vb, flt;
        repeat (2) @(posedge clk_sys);
        #1;
        exp_rt = exp_route(exp_route(exp_rt));
        va = level_a >= thr_a;
        vb = level_b >= thr_b;
        flt = !va || frame_power_fault;
        check_bit(local_fault_led, flt);
        check_bit(frame_fault, flt);
        check_bit(relay_closed, flt);
        check_bit(fault_buzzer, flt && cfg_buzzer_en);
        check_bit(chan_a_low_power_led, !va);
        check_bit(chan_b_low_power_led, !vb);
        check_bit(route_second, exp_rt);
        check_bit(chan_a_selected_led, !exp_rt);
        check_bit(chan_b_selected_led, exp_rt);
        check_bit(module_ok_led, (exp_rt ? vb : va) && board_power_good);
    endtask

    task automatic rand_vec;
        seed = xs(seed);
        level_a <= ops_dbm_t'(seed[5:0] % 56 - 48);
        level_b <= ops_dbm_t'(seed[13:8] % 56 - 48);
        one_asserted <= seed[16] & seed[17];
        two_asserted <= seed[18] & seed[19];
        {cfg_switch_back, cfg_manual, cfg_buzzer_en, cfg_dual_contact} <= seed[23:20];
        frame_power_fault <= seed[24] & seed[25];
        board_power_good <= seed[26] | seed[27];
    endtask

    task automatic press_check(input logic [31:0] name, input logic [31:0] data);
        @(posedge clk_sys);
        button_press <= 1'b1;
        @(posedge clk_sys);
        button_press <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check_text(orientation_view_text, name);
        repeat (HOLD - 2) @(posedge clk_sys);
        #1 check_text(orientation_view_text, name);
        @(posedge clk_sys);
        #1 check_text(orientation_view_text, data);
    endtask

    task automatic toggle(input logic up, input logic [31:0] data);
        @(posedge clk_sys);
        toggle_up <= up;
        toggle_down <= !up;
        @(posedge clk_sys);
        toggle_up <= 1'b0;
        toggle_down <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check_text(orientation_view_text, data);
    endtask

    // Walks past the end so the clamp is seen
    task automatic thr_walk(input logic up, input int n, ref ops_dbm_t thr);
        for (int i = 0; i < n; i++) begin
            if (up && thr < `OPS_DBM_MAX) thr = thr + 8'sh01;
            if (!up && thr > `OPS_DBM_MIN) thr = thr - 8'sh01;
            toggle(up, fmt(thr));
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    initial begin
        {button_press, toggle_up, toggle_down, one_asserted, two_asserted} = '0;
        {cfg_switch_back, cfg_manual, cfg_buzzer_en, cfg_dual_contact} = '0;
        frame_power_fault = 1'b0;
        board_power_good = 1'b1;
        level_a = 8'sh00;
        level_b = 8'sh00;
        thr_a = `OPS_THR_RESET;
        thr_b = `OPS_THR_RESET;
        seed = 32'h00000002;
        exp_rt = 1'b0;
        failures = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 check_text(orientation_view_text, `OPS_TXT_POWER_FIRST);
        check_bit(orientation_view_upright, 1'b1);
        repeat (400) begin
            @(posedge clk_sys);
            rand_vec();
            settle();
        end
        @(posedge clk_sys);
        {cfg_manual, cfg_dual_contact, one_asserted, two_asserted} <= 4'hE;
        {frame_power_fault, board_power_good, cfg_buzzer_en} <= 3'h3;
        level_a <= 8'sh07;
        level_b <= 8'shD3;
        settle();
        press_check(`OPS_TXT_POWER_SECOND, fmt(8'shD3));
        press_check(`OPS_TXT_THR_FIRST, fmt(`OPS_THR_RESET));
        thr_walk(1'b0, 22, thr_a);
        press_check(`OPS_TXT_THR_SECOND, fmt(`OPS_THR_RESET));
        thr_walk(1'b1, 27, thr_b);
        press_check(`OPS_TXT_STATUS, `OPS_TXT_IN1_LOW);
        toggle(1'b1, `OPS_TXT_IN2_HIGH);
        toggle(1'b0, `OPS_TXT_RELAY_OPEN);
        toggle(1'b1, `OPS_TXT_ROUTE_FIRST);
        toggle(1'b1, `OPS_TXT_IN1_LOW);
        press_check(`OPS_TXT_ORIENT, `OPS_TXT_UPRIGHT);
        toggle(1'b0, `OPS_TXT_SIDEWAYS);
        check_bit(orientation_view_upright, 1'b0);
        press_check(`OPS_TXT_POWER_FIRST, fmt(8'sh07));
        @(posedge clk_sys);
        level_b <= 8'sh05;
        {one_asserted, two_asserted} <= 2'h1;
        settle();
        report_and_stop();
    end
endmodule

bind ops_ctrl ops_ctrl_asserts #(.NAME_HOLD_CYCLES(NAME_HOLD_CYCLES)) u_chk (.clk_sys,
    .sys_rst, .contact_input_one_n, .contact_input_two_n, .cfg_manual, .cfg_dual_contact,
    .cfg_buzzer_en, .frame_power_fault, .board_power_good, .button_press, .local_fault_led,
    .module_ok_led, .chan_a_selected_led, .chan_b_selected_led, .fault_buzzer, .frame_fault,
    .relay_closed, .route_second, .orientation_view_text);
